// [rtl/pimp_cap_if.sv]
`timescale 1ns/1ps

// carries the read-capture handshake between sequencer and capture register
interface pimp_cap_if;
    import pimp_pkg::*;
    logic clear;
    logic sample;
    pimp_data_t data;
    logic got;
    modport seq (output clear, output sample, input data, input got);
    modport cap (input clear, input sample, output data, output got);
endinterface : pimp_cap_if

// [rtl/pimp_capture.sv]
`timescale 1ns/1ps

module pimp_capture (
    input wire logic clk_i,            // system clock
    input wire logic rst_i,            // sync reset, high
    input wire logic complete_n_i,     // read-complete pin, low active
    input wire pimp_pkg::pimp_data_t dout_n_i, // data output pins, low active
    pimp_cap_if.cap cap                // handshake to sequencer
);
    import pimp_pkg::*;

    pimp_data_t data_reg;
    pimp_data_t data_next;
    logic got_reg;
    logic got_next;

    // outputs released read as one; a low pin means a stored one
    always_comb begin
        data_next = data_reg;
        got_next = got_reg;
        if (cap.clear) begin
            got_next = 1'b0;
        end
        if (cap.sample && !complete_n_i && !got_reg) begin
            data_next = ~dout_n_i;
            got_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_reg <= '0;
            got_reg <= 1'b0;
        end else begin
            data_reg <= data_next;
            got_reg <= got_next;
        end
    end

    assign cap.data = data_reg;
    assign cap.got = got_reg;
endmodule : pimp_capture

// [rtl/pimp_host.sv]
`timescale 1ns/1ps
`include "pimp_params.svh"

module pimp_host (
    input wire logic CLOCK_I,                 // 125 MHz clock
    input wire logic RESET_I,                 // sync reset, high
    input wire logic REQ_VALID_I,             // user request valid
    output logic REQ_READY_O,                 // request taken this cycle
    input wire logic REQ_READ_I,              // 1 read, 0 write
    input wire pimp_pkg::pimp_addr_t REQ_ADDR_I, // word address
    input wire pimp_pkg::pimp_bank_t REQ_BANK_I, // bank address
    input wire pimp_pkg::pimp_data_t REQ_WDATA_I, // write data
    output logic RSP_VALID_O,                 // one-cycle end-of-cycle pulse
    output pimp_pkg::pimp_data_t RSP_RDATA_O, // read data
    output logic RSP_TIMEOUT_O,               // read of bank PIMP_BANK_SEL ended with no read-complete
    output logic MEM_INITIATE_O,              // initiate pin, high active
    output logic MEM_READ_O,                  // direction pin, high = read
    output pimp_pkg::pimp_addr_t MEM_ADDR_O,  // word address pins
    output pimp_pkg::pimp_bank_t MEM_BANK_O,  // bank address pins
    output pimp_pkg::pimp_data_t MEM_DIN_O,   // data input pins
    input wire logic MEM_COMPLETE_N_I,        // read-complete pin, low active
    input wire pimp_pkg::pimp_data_t MEM_DOUT_N_I // data output pins, low active
);
    import pimp_pkg::*;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    pimp_state_e state_reg;
    pimp_state_e state_next;
    pimp_cnt_t cnt_reg;
    pimp_cnt_t cnt_next;
    logic read_reg;
    logic read_next;
    pimp_addr_t addr_reg;
    pimp_addr_t addr_next;
    pimp_bank_t bank_reg;
    pimp_bank_t bank_next;
    pimp_data_t din_reg;
    pimp_data_t din_next;
    logic rsp_reg;
    logic rsp_next;
    logic tmo_reg;
    logic tmo_next;
    pimp_data_t rdata_reg;
    pimp_data_t rdata_next;

    pimp_cap_if cap_bus ();

    function automatic pimp_cnt_t cycle_len(input logic rd);
        cycle_len = rd ? pimp_cnt_t'(`PIMP_READ_CYC) : pimp_cnt_t'(`PIMP_WRITE_CYC);
    endfunction : cycle_len

    assign REQ_READY_O = (state_reg == PIMP_IDLE);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        read_next = read_reg;
        addr_next = addr_reg;
        bank_next = bank_reg;
        din_next = din_reg;
        rsp_next = 1'b0;
        tmo_next = tmo_reg;
        rdata_next = rdata_reg;
        cap_bus.clear = 1'b0;
        cap_bus.sample = 1'b0;
        case (state_reg)
            PIMP_IDLE: begin
                if (REQ_VALID_I) begin
                    // lines latched on the same edge that raises initiate
                    read_next = REQ_READ_I;
                    addr_next = REQ_ADDR_I;
                    bank_next = REQ_BANK_I;
                    din_next = REQ_WDATA_I;
                    cnt_next = pimp_cnt_t'(`PIMP_INIT_CYC);
                    cap_bus.clear = 1'b1;
                    state_next = PIMP_PULSE;
                end
            end
            PIMP_PULSE: begin
                // 7 cycles = 56 ns, inside the 50..450 ns window
                cnt_next = cnt_reg - pimp_cnt_t'(1);
                if (cnt_reg == pimp_cnt_t'(1)) begin
                    cnt_next = cycle_len(read_reg) - pimp_cnt_t'(`PIMP_INIT_CYC);
                    state_next = PIMP_WAIT;
                end
            end
            PIMP_WAIT: begin
                // lines stay put for the full worst-case cycle time
                cap_bus.sample = read_reg;
                cnt_next = cnt_reg - pimp_cnt_t'(1);
                if (cnt_reg == pimp_cnt_t'(1)) begin
                    rsp_next = 1'b1;
                    rdata_next = cap_bus.got ? cap_bus.data : '0;
                    // unmatched bank means no answer by design, not a fault
                    tmo_next = read_reg && (bank_reg == `PIMP_BANK_SEL) && !cap_bus.got;
                    cnt_next = pimp_cnt_t'(`PIMP_DHOLD_CYC);
                    state_next = PIMP_GAP;
                end
            end
            PIMP_GAP: begin
                // small idle gap lets the device release its outputs
                cnt_next = cnt_reg - pimp_cnt_t'(1);
                if (cnt_reg == pimp_cnt_t'(1)) begin
                    state_next = PIMP_IDLE;
                end
            end
            default: begin
                state_next = PIMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            state_reg <= PIMP_IDLE;
            cnt_reg <= '0;
            read_reg <= 1'b1;
            addr_reg <= '0;
            bank_reg <= '0;
            din_reg <= '0;
            rsp_reg <= 1'b0;
            tmo_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            read_reg <= read_next;
            addr_reg <= addr_next;
            bank_reg <= bank_next;
            din_reg <= din_next;
            rsp_reg <= rsp_next;
            tmo_reg <= tmo_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------
    pimp_capture u_capture (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .complete_n_i(MEM_COMPLETE_N_I),
        .dout_n_i(MEM_DOUT_N_I),
        .cap(cap_bus)
    );

    assign MEM_INITIATE_O = (state_reg == PIMP_PULSE);
    assign MEM_READ_O = read_reg;
    assign MEM_ADDR_O = addr_reg;
    assign MEM_BANK_O = bank_reg;
    assign MEM_DIN_O = din_reg;
    assign RSP_VALID_O = rsp_reg;
    assign RSP_RDATA_O = rdata_reg;
    assign RSP_TIMEOUT_O = tmo_reg;
endmodule : pimp_host

// [rtl/pimp_params.svh]
`ifndef PIMP_PARAMS_SVH
`define PIMP_PARAMS_SVH

// widths of the memory unit pins, and the bank address this unit answers to
`define PIMP_DATA_W 18
`define PIMP_ADDR_W 12
`define PIMP_BANK_W 4
`define PIMP_BANK_SEL 4'hF

// times in ns as printed, and the clock period in ns
`define PIMP_CLK_NS 8
`define PIMP_INIT_MIN_NS 50
`define PIMP_INIT_MAX_NS 450
`define PIMP_READ_CYC_NS 1200
`define PIMP_WRITE_CYC_NS 1000
`define PIMP_RC_MAX_NS 450
`define PIMP_DHOLD_MIN_NS 150

// cycle counts: least and longest times all round up
`define PIMP_INIT_CYC ((`PIMP_INIT_MIN_NS + `PIMP_CLK_NS - 1) / `PIMP_CLK_NS)
`define PIMP_READ_CYC ((`PIMP_READ_CYC_NS + `PIMP_CLK_NS - 1) / `PIMP_CLK_NS)
`define PIMP_WRITE_CYC ((`PIMP_WRITE_CYC_NS + `PIMP_CLK_NS - 1) / `PIMP_CLK_NS)
`define PIMP_DHOLD_CYC ((`PIMP_DHOLD_MIN_NS + `PIMP_CLK_NS - 1) / `PIMP_CLK_NS)
`define PIMP_RC_CYC ((`PIMP_RC_MAX_NS + `PIMP_CLK_NS - 1) / `PIMP_CLK_NS)
`define PIMP_CNT_W 8

`endif

// [rtl/pimp_pkg.sv]
`include "pimp_params.svh"

package pimp_pkg;
    typedef logic [`PIMP_DATA_W-1:0] pimp_data_t;
    typedef logic [`PIMP_ADDR_W-1:0] pimp_addr_t;
    typedef logic [`PIMP_BANK_W-1:0] pimp_bank_t;
    typedef logic [`PIMP_CNT_W-1:0] pimp_cnt_t;
    typedef enum logic [2:0] {
        PIMP_IDLE,
        PIMP_PULSE,
        PIMP_WAIT,
        PIMP_GAP
    } pimp_state_e;
endpackage : pimp_pkg

// [test/pimp_host_properties.sv]
`timescale 1ns/1ps
`include "pimp_params.svh"

module pimp_host_properties (
    input wire logic CLOCK_I, // clock
    input wire logic RESET_I, // reset
    input wire logic REQ_VALID_I, // request valid
    input wire logic REQ_READY_O, // request ready
    input wire logic REQ_READ_I, // read select
    input wire pimp_pkg::pimp_addr_t REQ_ADDR_I, // address
    input wire pimp_pkg::pimp_bank_t REQ_BANK_I, // bank
    input wire pimp_pkg::pimp_data_t REQ_WDATA_I, // write data
    input wire logic RSP_VALID_O, // response pulse
    input wire pimp_pkg::pimp_data_t RSP_RDATA_O, // read data
    input wire logic RSP_TIMEOUT_O, // no read-complete
    input wire logic MEM_INITIATE_O, // initiate pin
    input wire logic MEM_READ_O, // direction pin
    input wire pimp_pkg::pimp_addr_t MEM_ADDR_O, // address pins
    input wire pimp_pkg::pimp_bank_t MEM_BANK_O, // bank pins
    input wire pimp_pkg::pimp_data_t MEM_DIN_O, // data in pins
    input wire logic MEM_COMPLETE_N_I, // read-complete pin
    input wire pimp_pkg::pimp_data_t MEM_DOUT_N_I // data out pins
);
    import pimp_pkg::*;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    init_width_a: assert property ($rose(MEM_INITIATE_O) |-> MEM_INITIATE_O[*7] ##1 !MEM_INITIATE_O)
        else $error("initiate width wrong");
    init_cause_a: assert property ($rose(MEM_INITIATE_O) |-> $past(REQ_VALID_I && REQ_READY_O))
        else $error("initiate without a taken request");
    read_time_a: assert property ($rose(MEM_INITIATE_O) && MEM_READ_O |-> ##[145:150] RSP_VALID_O)
        else $error("read cycle too long");
    write_time_a: assert property ($rose(MEM_INITIATE_O) && !MEM_READ_O |-> ##[120:125] RSP_VALID_O)
        else $error("write cycle too long");
    lines_held_a: assert property (!REQ_READY_O && !$past(REQ_READY_O)
        |-> $stable({MEM_READ_O, MEM_ADDR_O, MEM_BANK_O, MEM_DIN_O}))
        else $error("pins moved during a cycle");
    gap_ready_a: assert property (RSP_VALID_O |=> !RSP_VALID_O ##0 (!REQ_READY_O[*8] ##[8:13] REQ_READY_O))
        else $error("post-cycle gap wrong");
    write_nodata_a: assert property (RSP_VALID_O && !MEM_READ_O |-> RSP_RDATA_O == '0)
        else $error("write returned data");
    timeout_bank_a: assert property (RSP_VALID_O && RSP_TIMEOUT_O
        |-> MEM_READ_O && MEM_BANK_O == `PIMP_BANK_SEL)
        else $error("timeout on unselected unit");
endmodule : pimp_host_properties

// [test/pimp_mem_model.sv]
`timescale 1ns/1ps
`include "pimp_params.svh"

module pimp_mem_model (
    input wire logic init_i, // initiate
    input wire logic read_i, // 1 read, 0 write
    input wire pimp_pkg::pimp_addr_t addr_i, // word address
    input wire pimp_pkg::pimp_bank_t bank_i, // bank address
    input wire pimp_pkg::pimp_data_t din_i, // write data
    input int acc_ns_i, // access delay; 1192 or over answers too late
    output logic complete_n_o, // read-complete, pulled up
    output pimp_pkg::pimp_data_t dout_n_o // data out, pulled up
);
    import pimp_pkg::*;
    pimp_data_t mem [4096];
    pimp_addr_t a;
    initial begin
        complete_n_o = 1'b1;
        dout_n_o = '1;
        foreach (mem[i]) mem[i] = '0;
    end
    // released open-collector lines rise to the pull-up level
    always @(posedge init_i) begin
        #35;
        if (init_i && bank_i === `PIMP_BANK_SEL) begin
            a = addr_i;
            if (read_i) begin
                #(acc_ns_i - 35);
                dout_n_o = ~mem[a];
                complete_n_o = 1'b0;
                #300 complete_n_o = 1'b1;
                #200 dout_n_o = '1;
            end else begin
                #600 mem[a] = din_i;
            end
        end
    end
endmodule : pimp_mem_model

// [test/tb.sv]
`timescale 1ns/1ps
`include "pimp_params.svh"

module tb;
    import pimp_pkg::*;
    logic clk = 0, rst = 1, v = 0, rd = 0, rdy, rv, tmo, ini, mrd, cn;
    pimp_addr_t ad = '0, mad;
    pimp_bank_t bk = '0, mbk;
    pimp_data_t wd = '0, rdat, mdi, dn;
    pimp_data_t shadow [int];
    int acc = 200, num_errors = 0, comparisons = 0;
    pimp_host dut (.CLOCK_I(clk), .RESET_I(rst), .REQ_VALID_I(v), .REQ_READY_O(rdy),
        .REQ_READ_I(rd), .REQ_ADDR_I(ad), .REQ_BANK_I(bk), .REQ_WDATA_I(wd),
        .RSP_VALID_O(rv), .RSP_RDATA_O(rdat), .RSP_TIMEOUT_O(tmo), .MEM_INITIATE_O(ini),
        .MEM_READ_O(mrd), .MEM_ADDR_O(mad), .MEM_BANK_O(mbk), .MEM_DIN_O(mdi),
        .MEM_COMPLETE_N_I(cn), .MEM_DOUT_N_I(dn));
    pimp_mem_model mem (.init_i(ini), .read_i(mrd), .addr_i(mad), .bank_i(mbk), .din_i(mdi),
        .acc_ns_i(acc), .complete_n_o(cn), .dout_n_o(dn));
    initial forever #4 clk = ~clk;
    task automatic chk_d(input pimp_data_t g, input pimp_data_t e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t data %h expected %h", $time, g, e);
        end
    endtask : chk_d
    task automatic chk_b(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, g, e);
        end
    endtask : chk_b
    task automatic op(input logic r, input pimp_addr_t a, input pimp_bank_t b, input pimp_data_t d);
        logic sel;
        pimp_data_t e;
        int n;
        sel = (b === 4'hF);
        e = (r && sel && acc < 500 && shadow.exists(a)) ? shadow[a] : '0;
        if (!r && sel) shadow[a] = d;
        v = 1; rd = r; ad = a; bk = b; wd = d;
        n = 0;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 400);
        #1 v = 0;
        wd = ~d; // data lines are ignored once taken, on a read or a write
        n = 0;
        do begin @(posedge clk); #1; n++; end while (rv !== 1'b1 && n < 300);
        chk_b(rv, 1'b1);
        chk_d(rdat, e);
        chk_b(tmo, r && sel && acc > 1000);
    endtask : op
    task stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        #400000;
        num_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(69));
        repeat (5) @(posedge clk);
        #1 rst = 0;
        op(0, 12'hFFF, 4'hF, 18'h3FFFF);
        op(0, 12'hFFF, 4'hE, 18'h00001);
        op(1, 12'hFFF, 4'hF, '0);
        op(1, 12'h000, 4'h7, '0);
        acc = 480;
        op(1, 12'hFFF, 4'hF, '0);
        acc = 2000;
        op(1, 12'hFFF, 4'hF, '0);
        repeat (300) @(posedge clk);
        #1;
        repeat (40) begin
            acc = 40 + $urandom % 441;
            op($urandom % 2, {$urandom % 2 ? 8'hFF : 8'h00, 4'($urandom % 4)},
                $urandom % 4 ? 4'hF : 4'($urandom), 18'($urandom));
        end
        stop_test();
    end
endmodule : tb

bind pimp_host pimp_host_properties u_props (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_READY_O(REQ_READY_O), .REQ_READ_I(REQ_READ_I),
    .REQ_ADDR_I(REQ_ADDR_I), .REQ_BANK_I(REQ_BANK_I), .REQ_WDATA_I(REQ_WDATA_I),
    .RSP_VALID_O(RSP_VALID_O), .RSP_RDATA_O(RSP_RDATA_O), .RSP_TIMEOUT_O(RSP_TIMEOUT_O),
    .MEM_INITIATE_O(MEM_INITIATE_O), .MEM_READ_O(MEM_READ_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_BANK_O(MEM_BANK_O), .MEM_DIN_O(MEM_DIN_O), .MEM_COMPLETE_N_I(MEM_COMPLETE_N_I),
    .MEM_DOUT_N_I(MEM_DOUT_N_I));
